// ==== logic/ocpwm_unit.sv ====
// output compare and pwm unit with its avalon-mm register slave
//
// How it works
// (R1) enable bit set runs the compare unit; cleared, the unit is off.
// (R2) idle stop bit set freezes the unit while the device idles.
// (R3) wide select compares full 32 bits; clear compares low 16 bits.
// (R4) timer source select picks third timer when set, second when clear.
// (R5) pwm fault flag is read-only; hardware sets and clears it.
// (R6) fault flag means something only in mode 111, reads zero otherwise.
// (R7) mode 111 is pwm honouring fault input; 110 is pwm ignoring it.
// (R8) mode 101 starts pin low then makes continuous pulses.
// (R9) mode 100 starts pin low then makes exactly one pulse.
// (R10) mode 011 inverts the pin on every primary compare match.
// (R11) mode 010 starts pin high; a match drives it low.
// (R12) mode 001 starts pin low; a match drives it high.
// (R13) mode 000 disables comparing while the unit stays powered.
// (R14) software avoids register access right after clearing enable at 1:1.
// (R15) control bits 31-16, 14 and 12-6 always read zero.
// (R16) primary match starts pulses; secondary ends them or sets pwm duty.
// (R17) with fault enabled, a fault forces pin low until hardware clears flag.
`default_nettype none

module ocpwm_unit
  import ocpwm_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // avalon-mm slave
  input  wire ocpwm_av_req_t      av_req,
  output logic [31:0]             av_readdata,
  output logic                    av_waitrequest,
  // time bases
  input  wire logic [TIMER_W-1:0] second_timer,
  input  wire logic [TIMER_W-1:0] third_timer,
  // device state and fault input
  input  wire logic               idle_mode,
  input  wire logic               fault_n,
  // compare output
  output logic                    compare_output_pin,
  output logic                    compare_event
);

  // refuse widths the narrow/wide split cannot serve
  if (TIMER_W <= OCPWM_NARROW_W || TIMER_W > 32) begin : g_bad_width
    $error("ocpwm_unit: TIMER_W must lie in 17..32");
  end

  // whole state of the unit
  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic [31:0]        ctrl;
    logic [TIMER_W-1:0] pri;
    logic [TIMER_W-1:0] sec;
    logic               fault;
    logic               pin;
    logic               event_p;
    logic               single_done;
    logic               last_on;
    logic [2:0]         last_mode;
    logic               eq_pri_d;
    logic               eq_sec_d;
    logic               zero_d;
  } ocpwm_state_t;

  ocpwm_state_t st;
  ocpwm_state_t next_st;

  logic        req;
  logic        done;
  logic        ctrl_on;
  logic        idle_stop;
  logic        wide;
  logic        tsel;
  logic [2:0]  mode;
  logic        frozen;
  logic        running;
  logic        cfg_change;
  logic        eq_pri;
  logic        eq_sec;
  logic        at_zero;
  logic        hit_p;
  logic        hit_s;
  logic        hit_z;
  logic        duty_nonzero;
  logic [31:0] ctrl_view;

  // control fields
  assign ctrl_on   = st.ctrl[OCPWM_ON_BIT];
  assign idle_stop = st.ctrl[OCPWM_IDLE_BIT];
  assign wide      = st.ctrl[OCPWM_WIDE_BIT];
  assign tsel      = st.ctrl[OCPWM_TSEL_BIT];
  assign mode      = st.ctrl[OCPWM_MODE_LO +: 3];

  // idle freezes everything except the register slave and the off path
  assign frozen     = idle_stop && idle_mode; // R2
  assign running    = ctrl_on && !frozen && (mode != OCPWM_MODE_OFF); // R1 R13
  assign cfg_change = ctrl_on && !frozen && (!st.last_on || mode != st.last_mode);

  ocpwm_compare #(
    .TIMER_W (TIMER_W)
  ) u_compare (
    .second_timer            (second_timer),
    .third_timer             (third_timer),
    .timer_source_select     (tsel),
    .wide_compare_select     (wide),
    .primary_compare_value   (st.pri),
    .secondary_compare_value (st.sec),
    .eq_primary              (eq_pri),
    .eq_secondary            (eq_sec),
    .at_zero                 (at_zero)
  );

  // matches are edges: a prescaled timer may sit on one value many cycles
  assign hit_p = eq_pri && !st.eq_pri_d; // R16
  assign hit_s = eq_sec && !st.eq_sec_d; // R16
  assign hit_z = at_zero && !st.zero_d;

  // a zero duty keeps the pin low for the whole period
  assign duty_nonzero = wide ? (st.sec != '0)
                             : (st.sec[OCPWM_NARROW_W-1:0] != 16'h0);

  // control readback: only implemented bits, flag masked outside mode 111
  always_comb begin
    ctrl_view = st.ctrl & OCPWM_CTRL_WMASK; // R15
    ctrl_view[OCPWM_FLT_BIT] = st.fault && (mode == OCPWM_MODE_PWM_FLT); // R6
  end

  // bus handshake: the answer comes one cycle after the request shows
  assign req            = av_req.read || av_req.write;
  assign done           = req && st.ack;
  assign av_waitrequest = req && !st.ack;
  assign av_readdata    = st.rdata;
  assign compare_output_pin = st.pin;
  assign compare_event      = st.event_p;

  // next-state logic of the whole unit
  always_comb begin
    next_st         = st;
    next_st.ack     = req && !st.ack;
    next_st.event_p = 1'b0;

    // read data is captured in the waiting cycle, stands at the answer edge
    if (req && !st.ack) begin
      case (av_req.address)
        OCPWM_CTRL_IDX: next_st.rdata = ctrl_view;
        OCPWM_PRI_IDX:  next_st.rdata = 32'(st.pri);
        OCPWM_SEC_IDX:  next_st.rdata = 32'(st.sec);
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end

    // writes land at the answer edge; the fault bit is never writable
    if (done && av_req.write) begin
      case (av_req.address)
        OCPWM_CTRL_IDX: begin
          next_st.ctrl = ocpwm_be_merge(st.ctrl, av_req.writedata, av_req.byteenable)
                         & OCPWM_CTRL_WMASK & ~(32'h1 << OCPWM_FLT_BIT); // R5 R15
        end
        OCPWM_PRI_IDX: begin
          next_st.pri = TIMER_W'(ocpwm_be_merge(32'(st.pri), av_req.writedata,
                                                av_req.byteenable));
        end
        OCPWM_SEC_IDX: begin
          next_st.sec = TIMER_W'(ocpwm_be_merge(32'(st.sec), av_req.writedata,
                                                av_req.byteenable));
        end
        default: begin
        end
      endcase
    end

    // compare engine
    if (!ctrl_on) begin
      next_st.pin         = 1'b0; // R1
      next_st.fault       = 1'b0;
      next_st.last_on     = 1'b0;
      next_st.single_done = 1'b0;
    end else if (!frozen) begin
      next_st.last_on   = 1'b1;
      next_st.last_mode = mode;
      next_st.eq_pri_d  = eq_pri;
      next_st.eq_sec_d  = eq_sec;
      next_st.zero_d    = at_zero;
      if (cfg_change) begin
        // every mode starts low except set-low, which starts high
        next_st.pin         = (mode == OCPWM_MODE_SET_LOW); // R8 R9 R11 R12
        next_st.single_done = 1'b0;
        next_st.fault       = 1'b0;
      end else begin
        case (mode)
          OCPWM_MODE_OFF: begin
            next_st.pin = st.pin; // R13
          end
          OCPWM_MODE_SET_HIGH: begin
            if (hit_p) begin
              next_st.pin     = 1'b1; // R12
              next_st.event_p = 1'b1;
            end
          end
          OCPWM_MODE_SET_LOW: begin
            if (hit_p) begin
              next_st.pin     = 1'b0; // R11
              next_st.event_p = 1'b1;
            end
          end
          OCPWM_MODE_TOGGLE: begin
            if (hit_p) begin
              next_st.pin     = !st.pin; // R10
              next_st.event_p = 1'b1;
            end
          end
          OCPWM_MODE_SINGLE, OCPWM_MODE_CONT: begin
            // single pulse locks after its falling edge, continuous rearms
            if (hit_p && !st.single_done) begin
              next_st.pin     = 1'b1; // R8 R9 R16
              next_st.event_p = 1'b1;
            end else if (hit_s && st.pin) begin
              next_st.pin         = 1'b0; // R16
              next_st.single_done = (mode == OCPWM_MODE_SINGLE); // R9
              next_st.event_p     = 1'b1;
            end
          end
          default: begin
            // pwm: period starts at timer zero, secondary value sets duty
            if (mode == OCPWM_MODE_PWM_FLT) begin
              if (hit_z && fault_n) begin
                next_st.fault = 1'b0; // R5
              end
              if (!fault_n) begin
                next_st.fault = 1'b1; // R5 R7
              end
            end
            if (mode == OCPWM_MODE_PWM_FLT && (!fault_n || next_st.fault)) begin
              next_st.pin = 1'b0; // R17
            end else if (hit_z) begin
              next_st.pin     = duty_nonzero; // R7 R16
              next_st.event_p = 1'b1;
            end else if (hit_s) begin
              next_st.pin = 1'b0; // R16
            end
          end
        endcase
      end
    end
  end

  // one register stage for the whole state, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // checks on the driven behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  off_pin_low_a: assert property ( // R1
    !ctrl_on |=> !compare_output_pin
  ) else $error("pin not low one cycle after disable");

  idle_freeze_a: assert property ( // R2
    (ctrl_on && frozen) |=> $stable(compare_output_pin)
  ) else $error("pin moved while frozen in idle");

  narrow_match_a: assert property ( // R3
    (!wide && !tsel && second_timer[15:0] == st.pri[15:0]) |-> eq_pri
  ) else $error("narrow compare ignored low half match");

  timer_pick_a: assert property ( // R4
    (tsel && !eq_pri) |-> (third_timer != st.pri || !wide)
  ) else $error("third timer match missed with source select set");

  flag_hw_only_a: assert property ( // R5
    $rose(st.fault) |-> !$past(fault_n)
  ) else $error("fault flag set without a fault input");

  flag_zero_a: assert property ( // R6
    (mode != OCPWM_MODE_PWM_FLT) |-> !ctrl_view[OCPWM_FLT_BIT]
  ) else $error("fault flag visible outside fault pwm mode");

  fault_force_a: assert property ( // R17
    (running && !cfg_change && mode == OCPWM_MODE_PWM_FLT && !fault_n)
      |=> (!compare_output_pin && st.fault)
  ) else $error("fault did not force the pin low and set the flag");

  set_high_a: assert property ( // R12
    (running && !cfg_change && mode == OCPWM_MODE_SET_HIGH && hit_p)
      |=> compare_output_pin && compare_event
  ) else $error("set-high match did not raise the pin");

  toggle_flip_a: assert property ( // R10
    (running && !cfg_change && mode == OCPWM_MODE_TOGGLE && hit_p)
      |=> compare_output_pin != $past(compare_output_pin)
  ) else $error("toggle match did not invert the pin");

  init_high_a: assert property ( // R11
    (cfg_change && mode == OCPWM_MODE_SET_LOW) |=> compare_output_pin
  ) else $error("set-low mode did not start high");

  single_once_a: assert property ( // R9
    (running && mode == OCPWM_MODE_SINGLE && st.single_done && !cfg_change)
      |=> !compare_output_pin [*2]
  ) else $error("single pulse mode pulsed twice");

  off_quiet_a: assert property ( // R13
    (ctrl_on && mode == OCPWM_MODE_OFF) |=> !compare_event
  ) else $error("compare event in disabled mode");

  bus_answer_a: assert property (
    (req && av_waitrequest) |=> !av_waitrequest
  ) else $error("bus answer not one cycle after request");

  cover_fault_c: cover property (
    running && mode == OCPWM_MODE_PWM_FLT && !fault_n ##1 st.fault
  );
  cover_single_c: cover property (
    running && mode == OCPWM_MODE_SINGLE ##[1:200] st.single_done
  );
  cover_toggle_c: cover property (
    running && mode == OCPWM_MODE_TOGGLE && hit_p
  );
  cover_pwm_c: cover property (
    running && mode == OCPWM_MODE_PWM && hit_z ##[1:200] hit_s
  );

endmodule

`default_nettype wire

// ==== include/ocpwm_pkg.sv ====
// shared constants, bus carrier and helpers of the output compare unit
`default_nettype none

package ocpwm_pkg;

  // register word indices on the avalon word address
  localparam int         OCPWM_ADDR_W   = 2;
  localparam logic [1:0] OCPWM_CTRL_IDX = 2'h0;
  localparam logic [1:0] OCPWM_PRI_IDX  = 2'h1;
  localparam logic [1:0] OCPWM_SEC_IDX  = 2'h2;

  // control register field positions
  localparam int OCPWM_ON_BIT    = 15;
  localparam int OCPWM_IDLE_BIT  = 13;
  localparam int OCPWM_WIDE_BIT  = 5;
  localparam int OCPWM_FLT_BIT   = 4;
  localparam int OCPWM_TSEL_BIT  = 3;
  localparam int OCPWM_MODE_LO   = 0;
  localparam int OCPWM_NARROW_W  = 16;

  // reset values and writable bits of the control register
  localparam logic [31:0] OCPWM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] OCPWM_CMP_RESET  = 32'h0000_0000;
  localparam logic [31:0] OCPWM_CTRL_WMASK = 32'h0000_a02f;

  // compare mode codes
  localparam logic [2:0] OCPWM_MODE_OFF      = 3'h0;
  localparam logic [2:0] OCPWM_MODE_SET_HIGH = 3'h1;
  localparam logic [2:0] OCPWM_MODE_SET_LOW  = 3'h2;
  localparam logic [2:0] OCPWM_MODE_TOGGLE   = 3'h3;
  localparam logic [2:0] OCPWM_MODE_SINGLE   = 3'h4;
  localparam logic [2:0] OCPWM_MODE_CONT     = 3'h5;
  localparam logic [2:0] OCPWM_MODE_PWM      = 3'h6;
  localparam logic [2:0] OCPWM_MODE_PWM_FLT  = 3'h7;

  // bus answer latency in clock cycles after the request appears
  localparam int OCPWM_ANSWER_CYCLES = 1;

  // avalon-mm request from the master
  typedef struct packed {
    logic                    read;
    logic                    write;
    logic [OCPWM_ADDR_W-1:0] address;
    logic [31:0]             writedata;
    logic [3:0]              byteenable;
  } ocpwm_av_req_t;

  // merge write data into an old word under byte enables
  function automatic logic [31:0] ocpwm_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] wr_v,
                                                 input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wr_v[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// ==== logic/ocpwm_compare.sv ====
// equality detectors of the selected time base against both compare values
`default_nettype none

module ocpwm_compare
  import ocpwm_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  // time bases
  input  wire logic [TIMER_W-1:0] second_timer,
  input  wire logic [TIMER_W-1:0] third_timer,
  // configuration
  input  wire logic               timer_source_select,
  input  wire logic               wide_compare_select,
  input  wire logic [TIMER_W-1:0] primary_compare_value,
  input  wire logic [TIMER_W-1:0] secondary_compare_value,
  // equality results
  output logic                    eq_primary,
  output logic                    eq_secondary,
  output logic                    at_zero
);

  logic [TIMER_W-1:0] timer_sel;

  // narrow mode looks at the low half only, upper bits are dont-care
  function automatic logic [TIMER_W-1:0] fit(input logic wide, input logic [TIMER_W-1:0] v);
    logic [TIMER_W-1:0] res;
    res = v;
    if (!wide) begin
      res[TIMER_W-1:OCPWM_NARROW_W] = '0;
    end
    return res;
  endfunction

  // source pick, then width cut applied to all three operands
  assign timer_sel    = timer_source_select ? third_timer : second_timer; // R4
  assign eq_primary   = fit(wide_compare_select, timer_sel)
                        == fit(wide_compare_select, primary_compare_value); // R3
  assign eq_secondary = fit(wide_compare_select, timer_sel)
                        == fit(wide_compare_select, secondary_compare_value); // R3
  assign at_zero      = fit(wide_compare_select, timer_sel) == '0;

endmodule

`default_nettype wire

// ==== test/ocpwm_load.sv ====
// pin load model: listens to the compare output and counts rises and event pulses
`default_nettype none

module ocpwm_load (
  // clock, reset and count clear
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clr,
  // observed compare output
  input  wire logic        compare_output_pin,
  input  wire logic        compare_event,
  // counts read by the bench
  output logic      [15:0] rise_count,
  output logic      [15:0] event_count
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last_pin;

  // a resistive load only listens, it never drives the pin back
  always @(posedge clk_sys) begin
    if (reset || clr) begin
      rise_count  <= 16'h0;
      event_count <= 16'h0;
    end else begin
      if (compare_output_pin === 1'b1 && last_pin === 1'b0) rise_count <= rise_count + 16'h1;
      if (compare_event === 1'b1) event_count <= event_count + 16'h1;
    end
    // tracked through a clear too, so a pin already high is not counted as a rise
    last_pin <= reset ? 1'b0 : compare_output_pin;
  end
endmodule

`default_nettype wire

// ==== test/ocpwm_unit_tb.sv ====
// self-checking bench of the output compare unit with its pin load
`default_nettype none

module ocpwm_unit_tb import ocpwm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int P = 32;

  logic          clk_sys = 1'b0;
  logic          reset = 1'b1;
  ocpwm_av_req_t av_req = '0;
  logic [31:0]   av_readdata;
  logic          av_waitrequest;
  logic [31:0]   second_timer = 32'h1;
  logic [31:0]   third_timer = 32'h1;
  logic          idle_mode = 1'b0;
  logic          fault_n = 1'b1;
  logic          compare_output_pin;
  logic          compare_event;
  logic          clr = 1'b0;
  logic [15:0]   rise_count;
  logic [15:0]   event_count;
  int            err_total = 0;
  int            comparisons = 0;
  integer        seed = 32'h8a19747f;
  logic [31:0]   rd;
  logic [31:0]   pri;
  logic [31:0]   sec;

  always #50 clk_sys = ~clk_sys;

  ocpwm_unit #(.TIMER_W(32)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .second_timer(second_timer),
    .third_timer(third_timer), .idle_mode(idle_mode), .fault_n(fault_n),
    .compare_output_pin(compare_output_pin), .compare_event(compare_event));

  ocpwm_load load_u (
    .clk_sys(clk_sys), .reset(reset), .clr(clr), .compare_output_pin(compare_output_pin),
    .compare_event(compare_event), .rise_count(rise_count), .event_count(event_count));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("counts: %0d compares, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    @(posedge clk_sys);
    while (av_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        results();
      end
      @(posedge clk_sys);
    end
    rd = av_readdata;
    av_req <= '0;
    // an idle cycle after each access keeps clear of the cycle after a disable
    @(posedge clk_sys);
  endtask

  // compare values inside one timer period, optionally with junk above bit 15
  task automatic pick(input logic junk);
    pri = 32'(2 + {$random(seed)} % (P - 4));
    sec = pri + 32'(1 + {$random(seed)} % (P - 2 - pri));
    if (junk) begin
      pri[31:16] = 16'($random(seed)) | 16'h0100;
      sec[31:16] = 16'($random(seed));
    end
  endtask

  // the chosen time base walks three whole periods and rests at 1
  task automatic run(input logic use_third);
    for (int i = 2; i <= 3 * P + 1; i++) begin
      if (use_third) third_timer <= 32'(i % P);
      else second_timer <= 32'(i % P);
      @(posedge clk_sys);
    end
  endtask

  task automatic scen(input logic [31:0] cfg, input logic thd, input logic pin0,
                      input int rises, input int evs, input logic pin1);
    bus(1'b1, OCPWM_CTRL_IDX, 32'h0);
    bus(1'b1, OCPWM_PRI_IDX, pri);
    bus(1'b1, OCPWM_SEC_IDX, sec);
    bus(1'b1, OCPWM_CTRL_IDX, cfg);
    tick(2);
    check(compare_output_pin, pin0);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    run(thd);
    tick(3);
    check(rise_count, rises);
    if (evs >= 0) check(event_count, evs);
    check(compare_output_pin, pin1);
    $display("test cfg=%h done", cfg);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // reset values, unmapped word reads zero and ignores writes
    bus(1'b1, 2'h3, 32'hffff_ffff);
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, 2'(a), 32'h0);
      check(rd, 32'h0);
    end
    // random words: unimplemented bits and the fault flag never stick
    for (int i = 0; i < 8; i++) begin
      pri = $random(seed);
      bus(1'b1, OCPWM_CTRL_IDX, pri);
      bus(1'b0, OCPWM_CTRL_IDX, 32'h0);
      check(rd, pri & 32'h0000a02f);
      bus(1'b1, OCPWM_PRI_IDX, ~pri);
      bus(1'b0, OCPWM_PRI_IDX, 32'h0);
      check(rd, ~pri);
    end
    $display("test registers done");
    pick(1'b1);
    scen(32'h8000, 1'b0, 1'b0, 0, 0, 1'b0);
    scen(32'h8001, 1'b0, 1'b0, 1, 3, 1'b1);
    scen(32'h8002, 1'b0, 1'b1, 0, 3, 1'b0);
    scen(32'h8003, 1'b0, 1'b0, 2, 3, 1'b1);
    scen(32'h8004, 1'b0, 1'b0, 1, 2, 1'b0);
    scen(32'h8005, 1'b0, 1'b0, 3, 6, 1'b0);
    scen(32'h800e, 1'b1, 1'b0, 3, 3, 1'b1);
    scen(32'h0003, 1'b0, 1'b0, 0, 0, 1'b0);
    scen(32'h800b, 1'b0, 1'b0, 0, 0, 1'b0);
    scen(32'h8023, 1'b0, 1'b0, 0, 0, 1'b0);
    pick(1'b0);
    scen(32'h8023, 1'b0, 1'b0, 2, 3, 1'b1);
    idle_mode <= 1'b1;
    scen(32'ha003, 1'b0, 1'b0, 0, 0, 1'b0);
    scen(32'h8003, 1'b0, 1'b0, 2, 3, 1'b1);
    idle_mode <= 1'b0;
    // fault input held active while it is ignored
    fault_n <= 1'b0;
    scen(32'h8006, 1'b0, 1'b0, 3, 3, 1'b1);
    bus(1'b0, OCPWM_CTRL_IDX, 32'h0);
    check(rd[4], 1'b0);
    fault_n <= 1'b1;
    scen(32'h8007, 1'b0, 1'b0, 3, 3, 1'b1);
    fault_n <= 1'b0;
    tick(2);
    check(compare_output_pin, 1'b0);
    fault_n <= 1'b1;
    bus(1'b0, OCPWM_CTRL_IDX, 32'h0);
    check(rd[4], 1'b1);
    check(compare_output_pin, 1'b0);
    run(1'b0);
    tick(3);
    bus(1'b0, OCPWM_CTRL_IDX, 32'h0);
    check(rd[4], 1'b0);
    $display("test fault done");
    results();
  end
endmodule

`default_nettype wire
